// [core/avae_pkg.sv]
// constants, offsets and reset values for the apparent and reactive energy block
package avae_pkg;
  // register word offsets on the serial register port
  localparam logic [15:0] ADDR_A_POWER_GAIN = 16'h4399;
  localparam logic [15:0] ADDR_B_POWER_GAIN = 16'h439A;
  localparam logic [15:0] ADDR_C_POWER_GAIN = 16'h439B;
  localparam logic [15:0] ADDR_VAR_HOUR_BASE = 16'hE406;
  localparam logic [15:0] ADDR_A_APPARENT_ENERGY = 16'hE40C;
  localparam logic [15:0] ADDR_C_APPARENT_ENERGY = 16'hE40E;
  localparam logic [15:0] ADDR_INTERRUPT_FLAGS_ZERO = 16'hE502;
  localparam logic [15:0] ADDR_INTERRUPT_ENABLES_ZERO = 16'hE5F0;
  localparam logic [15:0] ADDR_A_INST_APPARENT_POWER = 16'hE51E;
  localparam logic [15:0] ADDR_C_INST_APPARENT_POWER = 16'hE520;
  localparam logic [15:0] ADDR_NOMINAL_VOLTAGE = 16'hE533;
  localparam logic [15:0] ADDR_HALF_CYCLE_COUNT = 16'hE60C;
  localparam logic [15:0] ADDR_COMPUTATION_MODE = 16'hE60E;
  localparam logic [15:0] ADDR_ACCUMULATION_MODE = 16'hE7F0;
  localparam logic [15:0] ADDR_LINE_CYCLE_MODE = 16'hE702;
  localparam logic [15:0] ADDR_APPARENT_ENERGY_THRESHOLD = 16'hEA04;

  // field positions
  localparam int CONNECTION_SELECT_LSB = 4;
  localparam int NOMINAL_V_EN_LSB = 11;
  localparam int LINE_CYCLE_REACTIVE_BIT = 1;
  localparam int ZERO_CROSS_SEL_LSB = 3;
  localparam int READ_CLEARS_BIT = 6;
  localparam int HALF_FULL_BIT = 4;
  localparam int LINE_CYCLE_DONE_BIT = 5;
  localparam int HALF_FULL_WATCH_BIT = 30;
  localparam int THRESHOLD_ZERO_BITS = 27;
  localparam int GAIN_FRAC_BITS = 23;

  // connection select codes
  localparam logic [1:0] CONNECTION_SELECT_FOUR_WIRE = 2'h0;
  localparam logic [1:0] CONNECTION_SELECT_THREE_WIRE = 2'h1;
  localparam logic [1:0] CONNECTION_SELECT_MINUS_A = 2'h3;

  // values after reset
  localparam logic [7:0] THRESHOLD_RESET = 8'h03;
  localparam logic [23:0] GAIN_RESET = 24'h000000;
  localparam logic [15:0] HALF_CYCLE_COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPUTATION_MODE_RESET = 16'h0000;
  localparam logic [7:0] LINE_CYCLE_MODE_RESET = 8'h00;

  // scaling constants
  localparam logic [24:0] FULL_SCALE_POWER_CONSTANT = 25'd26991271;
  localparam logic [23:0] RMS_FULL_SCALE = 24'd3761808;
  localparam logic [47:0] VA_DIVISOR = 48'(RMS_FULL_SCALE) * 48'(RMS_FULL_SCALE) * 48'h10;

  // line cycle counter state
  typedef enum logic [0:0] {LC_IDLE = 1'b0, LC_COUNT = 1'b1} avae_lc_state_type;
endpackage

// [core/avae_core.sv]
// apparent power, VA-hour and line-cycle var-hour accumulation with register port
// --------------------------------------------------------------------------
// Summary of operation
// - three-wire select: phase B rms shows A-C line rms, phase B powers zero
// - line-cycle reactive bit moves var energy only at period end
// - count selected zero crossings; transfer when count hits half-cycle register
// - per-phase zero-cross selects bits 5..3, any combination counted
// - apparent power is voltage rms times current rms, total only
// - instantaneous VA is V/Vfs times I/Ifs times power constant over 16
// - per-phase 24-bit gain scales instantaneous apparent power
// - no separate apparent power offset correction
// - nominal-voltage enable per phase replaces voltage rms by nominal register
// - nominal voltage held 24-bit internally, read as 32 with top byte zero
// - first stage adds VA each accumulation tick, pulses and subtracts threshold
// - second stage counts pulses in 32-bit accumulators seen on access
// - threshold is the 8-bit register followed by 27 zero bits, reset 3
// - VA-hour accumulators are signed 32-bit and wrap to 0x80000000
// - half-full flag sets whenever a pulse changes bit 30 of a VA-hour accumulator
// - masked half-full drives interrupt low; write one clears flag
// - read-clears bit set: energy register clears after its read
// - connection select bits 5..4: 00 four-wire, 01 A-C, 11 minus A
// --------------------------------------------------------------------------
`timescale 1ns/1ps
module avae_core
  import avae_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // dsp timing strobes
  input wire logic sample_tick,
  input wire logic acc_tick,
  // rms inputs
  input wire logic [23:0] vrms_a,
  input wire logic [23:0] vrms_b,
  input wire logic [23:0] vrms_c,
  input wire logic [23:0] vrms_line_ac,
  input wire logic [23:0] irms_a,
  input wire logic [23:0] irms_b,
  input wire logic [23:0] irms_c,
  // zero crossings of phases a, b, c
  input wire logic [2:0] zero_cross,
  // reactive first-stage pulses: a,b,c total then a,b,c fundamental
  input wire logic [5:0] var_pulse,
  input wire logic [5:0] var_negative,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // derived outputs
  output logic [23:0] phase_b_voltage_rms,
  output logic interrupt_out_zero_n
);

  // ------------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------------
  logic [2:0][23:0] power_gain_q;
  logic [23:0] nominal_voltage_q;
  logic [15:0] half_cycle_count_q;
  logic [15:0] computation_mode_q;
  logic [7:0] line_cycle_mode_q;
  logic [7:0] accumulation_mode_q;
  logic [7:0] apparent_energy_threshold_q;
  logic [31:0] interrupt_flags_zero_q;
  logic [31:0] interrupt_enables_zero_q;

  logic [1:0] connection_select;
  logic [2:0] nominal_v_enable;
  logic line_cycle_reactive_enable;
  logic [2:0] zero_cross_phase_select;
  logic read_clears_energy;

  assign connection_select = accumulation_mode_q[CONNECTION_SELECT_LSB +: 2];
  assign nominal_v_enable = computation_mode_q[NOMINAL_V_EN_LSB +: 3];
  assign line_cycle_reactive_enable = line_cycle_mode_q[LINE_CYCLE_REACTIVE_BIT];
  assign zero_cross_phase_select = line_cycle_mode_q[ZERO_CROSS_SEL_LSB +: 3];
  assign read_clears_energy = line_cycle_mode_q[READ_CLEARS_BIT];

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [1:0] count_ones3(input logic [2:0] v);
    count_ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  logic wr_go;
  logic rd_go;
  assign wr_go = ce && reg_wr;
  assign rd_go = ce && reg_rd;

  logic rd_va_hour;
  logic rd_var_hour;
  logic [1:0] rd_va_idx;
  logic [2:0] rd_var_idx;
  assign rd_va_hour = rd_go && in_range(reg_addr, ADDR_A_APPARENT_ENERGY, ADDR_C_APPARENT_ENERGY);
  assign rd_var_hour = rd_go && in_range(reg_addr, ADDR_VAR_HOUR_BASE, ADDR_VAR_HOUR_BASE + 16'h0005);
  assign rd_va_idx = 2'(reg_addr - ADDR_A_APPARENT_ENERGY);
  assign rd_var_idx = 3'(reg_addr - ADDR_VAR_HOUR_BASE);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_gain_q <= {3{GAIN_RESET}};
      nominal_voltage_q <= 24'h000000;
      half_cycle_count_q <= HALF_CYCLE_COUNT_RESET;
      computation_mode_q <= COMPUTATION_MODE_RESET;
      line_cycle_mode_q <= LINE_CYCLE_MODE_RESET;
      accumulation_mode_q <= 8'h00;
      apparent_energy_threshold_q <= THRESHOLD_RESET;
      interrupt_enables_zero_q <= 32'h00000000;
    end
    else if (wr_go)
    begin
      case (reg_addr)
        ADDR_A_POWER_GAIN: power_gain_q[0] <= reg_wdata[23:0];
        ADDR_B_POWER_GAIN: power_gain_q[1] <= reg_wdata[23:0];
        ADDR_C_POWER_GAIN: power_gain_q[2] <= reg_wdata[23:0];
        ADDR_NOMINAL_VOLTAGE: nominal_voltage_q <= reg_wdata[23:0];
        ADDR_HALF_CYCLE_COUNT: half_cycle_count_q <= reg_wdata[15:0];
        ADDR_COMPUTATION_MODE: computation_mode_q <= reg_wdata[15:0];
        ADDR_LINE_CYCLE_MODE: line_cycle_mode_q <= reg_wdata[7:0];
        ADDR_ACCUMULATION_MODE: accumulation_mode_q <= reg_wdata[7:0];
        ADDR_APPARENT_ENERGY_THRESHOLD: apparent_energy_threshold_q <= reg_wdata[7:0];
        ADDR_INTERRUPT_ENABLES_ZERO: interrupt_enables_zero_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // phase b handling for delta connections
  // ------------------------------------------------------------------------
  logic [2:0][23:0] v_in;
  logic [2:0][23:0] i_in;
  always_comb
  begin
    v_in = {vrms_c, vrms_b, vrms_a};
    i_in = {irms_c, irms_b, irms_a};
    if (connection_select == CONNECTION_SELECT_THREE_WIRE)
    begin
      v_in[1] = vrms_line_ac;
      i_in[1] = 24'h000000;
    end
    else if (connection_select == CONNECTION_SELECT_MINUS_A)
      v_in[1] = vrms_a;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phase_b_voltage_rms <= 24'h000000;
    else if (ce)
      phase_b_voltage_rms <= v_in[1];
  end

  // ------------------------------------------------------------------------
  // apparent power and two-stage energy accumulation, per phase
  // ------------------------------------------------------------------------
  localparam logic [36:0] ONE_PULSE_ZERO = 37'h0;
  logic [36:0] threshold;
  assign threshold = {2'h0, apparent_energy_threshold_q, {THRESHOLD_ZERO_BITS{1'b0}}};

  logic [2:0][23:0] inst_va_q;
  logic [2:0][25:0] gained_va_q;
  logic [2:0][36:0] stage1_q;
  logic [2:0] stage1_pulse;
  logic [2:0][31:0] va_hour_q;
  logic [2:0] half_full_event;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_phase
      logic [23:0] v_sel;
      logic [72:0] raw;
      logic [48:0] gain_prod;
      logic [36:0] stage1_sum;
      logic [31:0] va_hour_inc;

      // nominal voltage takes the place of the measured rms when enabled
      assign v_sel = nominal_v_enable[p] ? nominal_voltage_q : v_in[p];
      // total apparent power only; offsets live in the rms paths
      assign raw = 73'(v_sel) * 73'(i_in[p]) * 73'(FULL_SCALE_POWER_CONSTANT);
      assign gain_prod = 49'($signed({1'b0, inst_va_q[p]})) *
        49'($signed({1'b0, 24'h800000}) + $signed({{1{power_gain_q[p][23]}}, power_gain_q[p]}));
      assign stage1_sum = stage1_q[p] + {{11{gained_va_q[p][25]}}, gained_va_q[p]};
      assign stage1_pulse[p] = acc_tick && ($signed(stage1_sum) >= $signed(threshold));
      assign va_hour_inc = va_hour_q[p] + 32'h00000001;
      assign half_full_event[p] = ce && stage1_pulse[p] &&
        (va_hour_inc[HALF_FULL_WATCH_BIT] != va_hour_q[p][HALF_FULL_WATCH_BIT]);

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          inst_va_q[p] <= 24'h000000;
          gained_va_q[p] <= 26'h0000000;
        end
        else if (ce && sample_tick)
        begin
          inst_va_q[p] <= 24'(raw / 73'(VA_DIVISOR));
          gained_va_q[p] <= 26'(gain_prod >>> GAIN_FRAC_BITS);
        end
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          stage1_q[p] <= ONE_PULSE_ZERO;
        else if (ce && acc_tick)
          stage1_q[p] <= stage1_pulse[p] ? stage1_sum - threshold : stage1_sum;
      end

      // a pulse landing in the clearing read cycle is kept, not lost
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          va_hour_q[p] <= 32'h00000000;
        else if (ce)
        begin
          if (rd_va_hour && read_clears_energy && rd_va_idx == 2'(p))
            va_hour_q[p] <= {31'h0, stage1_pulse[p]};
          else if (stage1_pulse[p])
            va_hour_q[p] <= va_hour_inc;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------------
  // reactive energy: free running or line-cycle synchronised
  // ------------------------------------------------------------------------
  avae_lc_state_type lc_state_q;
  logic [15:0] zx_count_q;
  logic [16:0] zx_count_next;
  logic line_cycle_end;
  logic [5:0][31:0] var_acc_q;
  logic [5:0][31:0] var_hour_q;

  assign zx_count_next = {1'b0, zx_count_q} + {15'h0, count_ones3(zero_cross & zero_cross_phase_select)};
  assign line_cycle_end = ce && (lc_state_q == LC_COUNT) && (half_cycle_count_q != 16'h0000) &&
    (zx_count_next >= {1'b0, half_cycle_count_q});

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lc_state_q <= LC_IDLE;
      zx_count_q <= 16'h0000;
    end
    else if (ce)
    begin
      case (lc_state_q)
        LC_IDLE:
        begin
          zx_count_q <= 16'h0000;
          if (line_cycle_reactive_enable)
            lc_state_q <= LC_COUNT;
        end
        LC_COUNT:
        begin
          if (!line_cycle_reactive_enable)
            lc_state_q <= LC_IDLE;
          zx_count_q <= line_cycle_end ? 16'h0000 : zx_count_next[15:0];
        end
        default: lc_state_q <= LC_IDLE;
      endcase
    end
  end

  genvar r;
  generate
    for (r = 0; r < 6; r = r + 1)
    begin : g_var
      logic [31:0] step;
      assign step = var_negative[r] ? 32'hFFFFFFFF : 32'h00000001;

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          var_acc_q[r] <= 32'h00000000;
          var_hour_q[r] <= 32'h00000000;
        end
        else if (ce)
        begin
          if (line_cycle_end)
          begin
            var_hour_q[r] <= var_acc_q[r] + (var_pulse[r] ? step : 32'h00000000);
            var_acc_q[r] <= 32'h00000000;
          end
          else if (rd_var_hour && read_clears_energy && rd_var_idx == 3'(r))
          begin
            var_acc_q[r] <= var_pulse[r] ? step : 32'h00000000;
            var_hour_q[r] <= 32'h00000000;
          end
          else
          begin
            if (var_pulse[r])
              var_acc_q[r] <= var_acc_q[r] + step;
            if (!line_cycle_reactive_enable)
              var_hour_q[r] <= var_acc_q[r] + (var_pulse[r] ? step : 32'h00000000);
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------------
  // status flags and interrupt pin
  // ------------------------------------------------------------------------
  logic [31:0] flag_set;
  logic [31:0] flag_clear;
  always_comb
  begin
    flag_set = 32'h00000000;
    flag_set[HALF_FULL_BIT] = |half_full_event;
    flag_set[LINE_CYCLE_DONE_BIT] = line_cycle_end;
    flag_clear = (wr_go && reg_addr == ADDR_INTERRUPT_FLAGS_ZERO) ? reg_wdata : 32'h00000000;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      interrupt_flags_zero_q <= 32'h00000000;
    else if (ce)
      interrupt_flags_zero_q <= (interrupt_flags_zero_q & ~flag_clear) | flag_set;
  end

  // low while any enabled flag is pending
  assign interrupt_out_zero_n = ~|(interrupt_flags_zero_q & interrupt_enables_zero_q);

  // ------------------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (rd_va_hour)
          reg_rdata <= va_hour_q[rd_va_idx];
        else if (rd_var_hour)
          reg_rdata <= line_cycle_reactive_enable ? var_hour_q[rd_var_idx] : var_acc_q[rd_var_idx];
        else if (in_range(reg_addr, ADDR_A_INST_APPARENT_POWER, ADDR_C_INST_APPARENT_POWER))
          reg_rdata <= {8'h00, inst_va_q[2'(reg_addr - ADDR_A_INST_APPARENT_POWER)]};
        else
        begin
          case (reg_addr)
            ADDR_A_POWER_GAIN: reg_rdata <= {{8{power_gain_q[0][23]}}, power_gain_q[0]};
            ADDR_B_POWER_GAIN: reg_rdata <= {{8{power_gain_q[1][23]}}, power_gain_q[1]};
            ADDR_C_POWER_GAIN: reg_rdata <= {{8{power_gain_q[2][23]}}, power_gain_q[2]};
            ADDR_NOMINAL_VOLTAGE: reg_rdata <= {8'h00, nominal_voltage_q};
            ADDR_HALF_CYCLE_COUNT: reg_rdata <= {16'h0000, half_cycle_count_q};
            ADDR_COMPUTATION_MODE: reg_rdata <= {16'h0000, computation_mode_q};
            ADDR_LINE_CYCLE_MODE: reg_rdata <= {24'h000000, line_cycle_mode_q};
            ADDR_ACCUMULATION_MODE: reg_rdata <= {24'h000000, accumulation_mode_q};
            ADDR_APPARENT_ENERGY_THRESHOLD: reg_rdata <= {24'h000000, apparent_energy_threshold_q};
            ADDR_INTERRUPT_FLAGS_ZERO: reg_rdata <= interrupt_flags_zero_q;
            ADDR_INTERRUPT_ENABLES_ZERO: reg_rdata <= interrupt_enables_zero_q;
            default: reg_rdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_half_full_set: assert property (|half_full_event |=> interrupt_flags_zero_q[HALF_FULL_BIT])
    else $error("half-full event did not set the flag");

  a_irq_low_pending: assert property (ce && interrupt_enables_zero_q[HALF_FULL_BIT] && |half_full_event
    |=> !interrupt_out_zero_n)
    else $error("enabled half-full flag did not pull the interrupt low");

  a_irq_held_low: assert property (!interrupt_out_zero_n && !(wr_go && reg_addr == ADDR_INTERRUPT_FLAGS_ZERO)
    && !(wr_go && reg_addr == ADDR_INTERRUPT_ENABLES_ZERO) |=> !interrupt_out_zero_n)
    else $error("interrupt released without a clear");

  a_pulse_subtract: assert property (ce && stage1_pulse[0] |=> stage1_q[0] == $past(g_phase[0].stage1_sum) - $past(threshold))
    else $error("first stage did not subtract the threshold");

  a_va_hour_count: assert property (ce && stage1_pulse[0] && !rd_va_hour |=> va_hour_q[0] == $past(va_hour_q[0]) + 32'h00000001)
    else $error("va-hour accumulator missed a pulse");

  a_read_clear: assert property (rd_va_hour && read_clears_energy && rd_va_idx == 2'h0 && !stage1_pulse[0]
    |=> va_hour_q[0] == 32'h00000000)
    else $error("read with reset did not clear the va-hour register");

  a_line_cycle_hold: assert property (ce && line_cycle_reactive_enable && lc_state_q == LC_COUNT && !line_cycle_end
    && !rd_var_hour |=> $stable(var_hour_q[0]))
    else $error("var-hour register moved before the line cycle ended");

  a_line_cycle_xfer: assert property (line_cycle_end && !var_pulse[0] |=> var_hour_q[0] == $past(var_acc_q[0])
    && var_acc_q[0] == 32'h00000000)
    else $error("line-cycle transfer lost energy");

  a_three_wire_b: assert property (ce && connection_select == CONNECTION_SELECT_THREE_WIRE |=> phase_b_voltage_rms == $past(vrms_line_ac))
    else $error("phase b rms is not the line voltage in three-wire mode");

  a_threshold_form: assert property (threshold[THRESHOLD_ZERO_BITS-1:0] == 27'h0 &&
    threshold[34:27] == apparent_energy_threshold_q)
    else $error("threshold not formed from register and zero bits");

endmodule

// [testbench/avae_host_model.sv]
// host processor model on the serial register port
`timescale 1ns/1ps
module avae_host_model
(
  // clock
  input wire logic clk,
  // register port
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h00000000;
  end
  // one write; strobe dropped a cycle later so wr and rd never overlap
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read answer sampled one edge after the taking edge
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// [testbench/apparent_reactive_energy_accum_tb.sv]
// self-checking bench for the apparent and reactive energy block
`timescale 1ns/1ps
module apparent_reactive_energy_accum_tb;
  import avae_pkg::*;
  logic clk, rst, sample_tick, acc_tick, reg_wr, reg_rd, reg_rvalid, irq_n;
  logic [23:0] va, vb, vc, vl, ia, ib, ic, pb;
  logic [2:0] zc;
  logic [5:0] vp;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, d;
  int err_total, samples_checked, cyc, n;
  logic [95:0] g, thr;
  logic reg_dummy;
  avae_core dut (.clk(clk), .rst(rst), .ce(1'b1), .sample_tick(sample_tick), .acc_tick(acc_tick),
    .vrms_a(va), .vrms_b(vb), .vrms_c(vc), .vrms_line_ac(vl), .irms_a(ia), .irms_b(ib), .irms_c(ic),
    .zero_cross(zc), .var_pulse(vp), .var_negative(6'h00), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .phase_b_voltage_rms(pb), .interrupt_out_zero_n(irq_n));
  avae_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected instantaneous VA from rms codes
  function automatic logic [23:0] exp_va(input logic [23:0] v, input logic [23:0] i);
    logic [95:0] p;
    p = 96'(v) * 96'(i) * 96'(FULL_SCALE_POWER_CONSTANT);
    return 24'(p / 96'(VA_DIVISOR));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
    logic ok;
    host.rd(a, d, ok);
    check({31'h0, ok}, 32'h1);
    check(d, exp);
  endtask
  task automatic pulse(input int k, input logic [2:0] z, input logic [5:0] p, input logic s, input logic t);
    repeat (k)
    begin
      @(posedge clk);
      zc <= z; vp <= p; sample_tick <= s; acc_tick <= t;
    end
    @(posedge clk);
    zc <= 3'h0; vp <= 6'h00; sample_tick <= 1'b0; acc_tick <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1; sample_tick = 1'b0; acc_tick = 1'b0; zc = 3'h0; vp = 6'h00;
    seed = 32'h2f12; err_total = 0; samples_checked = 0; cyc = 0;
    va = 24'h0; vb = 24'h0; vc = 24'h0; vl = 24'h0; ia = 24'h0; ib = 24'h0; ic = 24'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    check({31'h0, irq_n}, 32'h1);
    chk_rd(ADDR_APPARENT_ENERGY_THRESHOLD, 32'h3);
    chk_rd(16'h1234, 32'h0);
    // random rms codes; instantaneous VA per phase
    repeat (3)
    begin
      @(posedge clk);
      va <= 24'(xs()); vb <= 24'(xs()); vc <= 24'(xs()); vl <= 24'(xs());
      ia <= 24'(xs()); ib <= 24'(xs()); ic <= 24'(xs());
      pulse(1, 3'h0, 6'h00, 1'b1, 1'b0);
      chk_rd(ADDR_A_INST_APPARENT_POWER, {8'h00, exp_va(va, ia)});
      chk_rd(ADDR_A_INST_APPARENT_POWER + 16'h1, {8'h00, exp_va(vb, ib)});
      chk_rd(ADDR_C_INST_APPARENT_POWER, {8'h00, exp_va(vc, ic)});
      for (int k = 0; k < 4; k++)
      begin
        host.wr(ADDR_ACCUMULATION_MODE, 32'(k) << CONNECTION_SELECT_LSB);
        repeat (2) @(posedge clk);
        check({8'h0, pb}, {8'h0, (k == 1) ? vl : (k == 3) ? va : vb});
      end
      host.wr(ADDR_ACCUMULATION_MODE, 32'h0);
    end
    // nominal voltage replaces phase A voltage
    d = xs() & 32'h007FFFFF;
    host.wr(ADDR_NOMINAL_VOLTAGE, d);
    host.wr(ADDR_COMPUTATION_MODE, 32'h1 << NOMINAL_V_EN_LSB);
    chk_rd(ADDR_NOMINAL_VOLTAGE, d);
    pulse(1, 3'h0, 6'h00, 1'b1, 1'b0);
    chk_rd(ADDR_A_INST_APPARENT_POWER, {8'h00, exp_va(irms_a_val(), d[23:0])});
    host.wr(ADDR_COMPUTATION_MODE, 32'h0);
    // gained energy accumulation, count chosen away from a pulse boundary
    va <= RMS_FULL_SCALE;
    ia <= RMS_FULL_SCALE;
    host.wr(ADDR_APPARENT_ENERGY_THRESHOLD, 32'(THRESHOLD_RESET));
    host.wr(ADDR_A_POWER_GAIN, 32'h00400000);
    // gained value lags inst value by one sample strobe
    pulse(2, 3'h0, 6'h00, 1'b1, 1'b0);
    g = (96'(exp_va(RMS_FULL_SCALE, RMS_FULL_SCALE)) * 96'h00C00000) >> GAIN_FRAC_BITS;
    thr = 96'(THRESHOLD_RESET) << THRESHOLD_ZERO_BITS;
    n = 1000;
    while ((96'(n) * g) % thr < g) n++;
    pulse(n, 3'h0, 6'h00, 1'b0, 1'b1);
    chk_rd(ADDR_A_APPARENT_ENERGY, 32'((96'(n) * g) / thr));
    host.wr(ADDR_LINE_CYCLE_MODE, 32'h1 << READ_CLEARS_BIT);
    chk_rd(ADDR_A_APPARENT_ENERGY, 32'((96'(n) * g) / thr));
    chk_rd(ADDR_A_APPARENT_ENERGY, 32'h0);
    // var-hour tracking, then line-cycle hold and transfer; read_clears_energy kept low
    host.wr(ADDR_LINE_CYCLE_MODE, 32'h0);
    pulse(5, 3'h0, 6'h01, 1'b0, 1'b0);
    chk_rd(ADDR_VAR_HOUR_BASE, 32'h5);
    host.wr(ADDR_HALF_CYCLE_COUNT, 32'h2);
    host.wr(ADDR_LINE_CYCLE_MODE, 32'h0000000A);
    pulse(4, 3'h0, 6'h01, 1'b0, 1'b0);
    pulse(1, 3'h2, 6'h00, 1'b0, 1'b0);
    pulse(1, 3'h1, 6'h00, 1'b0, 1'b0);
    chk_rd(ADDR_VAR_HOUR_BASE, 32'h5);
    chk_rd(ADDR_INTERRUPT_FLAGS_ZERO, 32'h0);
    pulse(1, 3'h1, 6'h00, 1'b0, 1'b0);
    host.rd(ADDR_INTERRUPT_FLAGS_ZERO, d, reg_dummy);
    check({31'h0, d[LINE_CYCLE_DONE_BIT]}, 32'h1);
    chk_rd(ADDR_VAR_HOUR_BASE, 32'h9);
    wrap_up();
  end
  function automatic logic [23:0] irms_a_val();
    return ia;
  endfunction
endmodule
